// ### design/pin_sync.sv
`timescale 1ns/10ps
module pin_sync import udc_pkg::*; #(
    parameter int STAGES = SYNC_STAGES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pin,
    output logic level
);

    logic [STAGES-1:0] stage_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage_reg <= '0;
        end else begin
            stage_reg <= {stage_reg[STAGES-2:0], pin};
        end
    end

    // Accept a change only once the last two stages agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level <= 1'b0;
        end else if (stage_reg[STAGES-1] == stage_reg[STAGES-2]) begin
            level <= stage_reg[STAGES-1];
        end
    end

endmodule

// ### design/threshold_select.sv
`timescale 1ns/10ps
module threshold_select import udc_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic use_live,
    input wire logic [23:0] const_value,
    input wire logic [23:0] live_value,
    output logic [23:0] value
);

    logic [23:0] pick;

    always_comb begin
        pick = use_live ? live_value : const_value;
        // Out-of-range sources pin at the top of the span
        if (pick > CNT_MAX) begin
            pick = CNT_MAX;
        end
    end

    // Follows the source every cycle, so a live value is seen one cycle late
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            value <= CNT_ZERO;
        end else begin
            value <= pick;
        end
    end

endmodule

// ### design/udc_pkg.sv
package udc_pkg;

    // Count and threshold span
    localparam int CNT_W = 24;
    localparam logic [23:0] CNT_MAX = 24'h98967F;
    localparam logic [23:0] CNT_ZERO = 24'h000000;

    // APB map
    localparam int ADDR_W = 8;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] INIT_OFS = 8'h04;
    localparam logic [7:0] ON_OFS = 8'h08;
    localparam logic [7:0] OFF_OFS = 8'h0C;
    localparam logic [7:0] SCAN_OFS = 8'h10;
    localparam logic [7:0] COUNT_OFS = 8'h14;
    localparam logic [7:0] STATUS_OFS = 8'h18;

    // Control fields
    localparam int CTRL_W = 7;
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_SWRST_BIT = 1;
    localparam int CTRL_ON_LIVE_BIT = 2;
    localparam int CTRL_OFF_LIVE_BIT = 3;
    localparam int CTRL_HAS_INIT_BIT = 4;
    localparam int CTRL_HAS_REL_BIT = 5;
    localparam int CTRL_RETAIN_BIT = 6;

    // Status fields
    localparam int STAT_W = 4;
    localparam int STAT_Q_BIT = 0;
    localparam int STAT_RST_BIT = 1;
    localparam int STAT_RESTORED_BIT = 2;
    localparam int STAT_RUN_BIT = 3;

    // Reset values
    localparam logic [6:0] CTRL_RST = 7'h30;
    localparam logic [23:0] INIT_RST = 24'h000000;
    localparam logic [23:0] ON_RST = 24'h000000;
    localparam logic [23:0] OFF_RST = 24'h000000;

    // Scan period in clock cycles
    localparam int SCAN_W = 16;
    localparam logic [15:0] SCAN_RST = 16'h0001;
    localparam logic [15:0] SCAN_ONE = 16'h0001;
    localparam logic [15:0] SCAN_ZERO = 16'h0000;

    // Pin synchroniser depth
    localparam int SYNC_STAGES = 3;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN = 2'b10
    } run_state_e;

endpackage

// ### design/up_down_threshold_counter.sv
// Functional notes
// - Count only rising edges of count pulse
// - Step one: up when dir low, else down
// - Reset reloads initial value, clears switch output
// - While reset high: output low, edges ignored
// - Thresholds accept zero through 9999999
// - On at-or-above switch, off below release
// - Window mode: high between switch and release
// - Threshold from constant or live block value
// - Retention keeps count and output over power-loss
// - Without initial value, start from zero
// - Without release threshold, single-threshold comparison only
// - Compare thresholds once per scan cycle
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/10ps
module up_down_threshold_counter import udc_pkg::*; (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic count_pulse,
    input wire logic count_dir,
    input wire logic count_reset,
    input wire logic [23:0] on_live_value,
    input wire logic [23:0] off_live_value,
    input wire logic backup_valid,
    input wire logic [23:0] backup_count_in,
    input wire logic backup_switch_in,
    output logic backup_keep,
    output logic [23:0] backup_count_out,
    output logic backup_switch_out,
    output logic [23:0] count_value,
    output logic switch_out
);

    logic [1:0] rst_pipe_reg;
    logic rst_n;

    logic pulse_level;
    logic dir_level;
    logic reset_level;
    logic pulse_prev_reg;
    logic rise;
    logic reset_active;

    logic [6:0] ctrl_reg;
    logic [23:0] init_reg;
    logic [23:0] on_const_reg;
    logic [23:0] off_const_reg;
    logic [15:0] scan_div_reg;
    logic [15:0] scan_cnt_reg;
    logic scan_tick;

    logic [23:0] on_value;
    logic [23:0] off_value;
    logic [23:0] start_value;

    run_state_e state_reg;
    logic [23:0] count_reg;
    logic switch_reg;
    logic switch_next;
    logic restored_reg;

    logic setup;
    logic wr_en;
    logic [31:0] rd_data;
    logic rd_hit;

    // Reset release through two flops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_pipe_reg <= 2'b00;
        end else begin
            rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
        end
    end

    assign rst_n = rst_pipe_reg[1];

    // Pins arrive asynchronously; the sync delay caps the usable edge rate
    pin_sync u_sync_pulse (
        .clk(clk),
        .rst_n(rst_n),
        .pin(count_pulse),
        .level(pulse_level)
    );

    pin_sync u_sync_dir (
        .clk(clk),
        .rst_n(rst_n),
        .pin(count_dir),
        .level(dir_level)
    );

    pin_sync u_sync_reset (
        .clk(clk),
        .rst_n(rst_n),
        .pin(count_reset),
        .level(reset_level)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_prev_reg <= 1'b0;
        end else begin
            pulse_prev_reg <= pulse_level;
        end
    end

    assign rise = pulse_level & ~pulse_prev_reg;
    assign reset_active = reset_level | ctrl_reg[CTRL_SWRST_BIT];

    // APB slave, zero wait states; read data latched in the setup cycle
    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pwrite;
    assign pready = 1'b1;

    function automatic logic [23:0] clamp(input logic [31:0] v);
        if (v > {8'h00, CNT_MAX}) begin
            return CNT_MAX;
        end
        return v[23:0];
    endfunction

    always_comb begin
        rd_data = 32'h00000000;
        rd_hit = 1'b1;
        if (paddr == CTRL_OFS) begin
            rd_data = {25'h0000000, ctrl_reg};
        end else if (paddr == INIT_OFS) begin
            rd_data = {8'h00, init_reg};
        end else if (paddr == ON_OFS) begin
            rd_data = {8'h00, on_const_reg};
        end else if (paddr == OFF_OFS) begin
            rd_data = {8'h00, off_const_reg};
        end else if (paddr == SCAN_OFS) begin
            rd_data = {16'h0000, scan_div_reg};
        end else if (paddr == COUNT_OFS) begin
            rd_data = {8'h00, count_reg};
        end else if (paddr == STATUS_OFS) begin
            rd_data = {28'h0000000, (state_reg == ST_RUN), restored_reg, reset_active, switch_reg};
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata <= pwrite ? 32'h00000000 : rd_data;
            pslverr <= ~rd_hit;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= CTRL_RST;
        end else if (wr_en && paddr == CTRL_OFS) begin
            ctrl_reg <= pwdata[CTRL_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            init_reg <= INIT_RST;
        end else if (wr_en && paddr == INIT_OFS) begin
            init_reg <= clamp(pwdata);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            on_const_reg <= ON_RST;
            off_const_reg <= OFF_RST;
        end else if (wr_en && paddr == ON_OFS) begin
            on_const_reg <= clamp(pwdata);
        end else if (wr_en && paddr == OFF_OFS) begin
            off_const_reg <= clamp(pwdata);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scan_div_reg <= SCAN_RST;
        end else if (wr_en && paddr == SCAN_OFS) begin
            scan_div_reg <= pwdata[SCAN_W-1:0];
        end
    end

    // Scan cycle pacing; a period of zero behaves as one
    always_comb begin
        if (scan_div_reg == SCAN_ZERO) begin
            scan_tick = 1'b1;
        end else begin
            scan_tick = (scan_cnt_reg >= scan_div_reg - SCAN_ONE);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scan_cnt_reg <= SCAN_ZERO;
        end else if (scan_tick) begin
            scan_cnt_reg <= SCAN_ZERO;
        end else begin
            scan_cnt_reg <= scan_cnt_reg + SCAN_ONE;
        end
    end

    threshold_select u_on_sel (
        .clk(clk),
        .rst_n(rst_n),
        .use_live(ctrl_reg[CTRL_ON_LIVE_BIT]),
        .const_value(on_const_reg),
        .live_value(on_live_value),
        .value(on_value)
    );

    threshold_select u_off_sel (
        .clk(clk),
        .rst_n(rst_n),
        .use_live(ctrl_reg[CTRL_OFF_LIVE_BIT]),
        .const_value(off_const_reg),
        .live_value(off_live_value),
        .value(off_value)
    );

    assign start_value = ctrl_reg[CTRL_HAS_INIT_BIT] ? init_reg : CNT_ZERO;

    // Startup waits for software so the retention choice is known first
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (ctrl_reg[CTRL_RUN_BIT]) begin
                        state_reg <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (!ctrl_reg[CTRL_RUN_BIT]) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            restored_reg <= 1'b0;
        end else if (state_reg == ST_IDLE && ctrl_reg[CTRL_RUN_BIT]) begin
            restored_reg <= ctrl_reg[CTRL_RETAIN_BIT] & backup_valid;
        end
    end

    // Count saturates at both ends rather than wrapping
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= CNT_ZERO;
        end else if (state_reg == ST_IDLE) begin
            if (ctrl_reg[CTRL_RUN_BIT] && ctrl_reg[CTRL_RETAIN_BIT] && backup_valid) begin
                count_reg <= (backup_count_in > CNT_MAX) ? CNT_MAX : backup_count_in;
            end else begin
                count_reg <= start_value;
            end
        end else if (reset_active) begin
            count_reg <= start_value;
        end else if (rise) begin
            if (!dir_level) begin
                if (count_reg < CNT_MAX) begin
                    count_reg <= count_reg + 24'h000001;
                end
            end else begin
                if (count_reg != CNT_ZERO) begin
                    count_reg <= count_reg - 24'h000001;
                end
            end
        end
    end

    // Threshold rules applied to the count as it stands at the scan tick
    always_comb begin
        switch_next = switch_reg;
        if (!ctrl_reg[CTRL_HAS_REL_BIT]) begin
            switch_next = (count_reg >= on_value);
        end else if (on_value >= off_value) begin
            if (count_reg >= on_value) begin
                switch_next = 1'b1;
            end else if (count_reg < off_value) begin
                switch_next = 1'b0;
            end
        end else begin
            switch_next = (count_reg >= on_value) && (count_reg < off_value);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            switch_reg <= 1'b0;
        end else if (state_reg == ST_IDLE) begin
            if (ctrl_reg[CTRL_RUN_BIT] && ctrl_reg[CTRL_RETAIN_BIT] && backup_valid) begin
                switch_reg <= backup_switch_in;
            end else begin
                switch_reg <= 1'b0;
            end
        end else if (reset_active) begin
            switch_reg <= 1'b0;
        end else if (scan_tick) begin
            switch_reg <= switch_next;
        end
    end

    // Image for the battery-backed store; dropped when retention is off
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            backup_keep <= 1'b0;
            backup_count_out <= CNT_ZERO;
            backup_switch_out <= 1'b0;
        end else begin
            backup_keep <= ctrl_reg[CTRL_RETAIN_BIT] && (state_reg == ST_RUN);
            backup_count_out <= count_reg;
            backup_switch_out <= switch_reg;
        end
    end

    always_comb begin
        count_value = count_reg;
        switch_out = switch_reg;
    end

endmodule

// ### verification/pulse_source.sv
`timescale 1ns/10ps
module pulse_source (
    output logic pulse,
    output logic dir,
    output logic rst,
    input wire logic clk
);
    initial begin
        pulse = 1'b0;
        dir = 1'b0;
        rst = 1'b0;
    end
    // Level floor of 3 cycles keeps the edge rate inside the input filter
    task automatic burst(input int n, input logic d, input int w);
        int ww;
        ww = (w < 3) ? 3 : w;
        @(posedge clk);
        dir <= d;
        repeat (6) @(posedge clk);
        for (int k = 0; k < n; k++) begin
            pulse <= 1'b1;
            repeat (ww) @(posedge clk);
            pulse <= 1'b0;
            repeat (ww) @(posedge clk);
        end
    endtask
    task automatic hold_reset(input int c);
        @(posedge clk);
        rst <= 1'b1;
        repeat (c) @(posedge clk);
        rst <= 1'b0;
    endtask
endmodule

// ### verification/up_down_threshold_counter_monitor.sv
`timescale 1ns/10ps
module up_down_threshold_counter_monitor import udc_pkg::*; (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic count_reset,
    input wire logic [23:0] count_value,
    input wire logic switch_out
);
    logic [3:0] quiet_reg;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Steps are judged only well away from reloads and register writes
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            quiet_reg <= 4'h0;
        end else if (count_reset || (psel && pwrite)) begin
            quiet_reg <= 4'h0;
        end else if (quiet_reg != 4'hF) begin
            quiet_reg <= quiet_reg + 4'h1;
        end
    end
    a_ready_high: assert property (psel |-> pready) else $error("pready low in a transfer");
    a_err_unmapped: assert property (psel && penable && paddr > STATUS_OFS |-> pslverr)
        else $error("no error on unmapped address");
    a_err_mapped: assert property (psel && penable && paddr <= STATUS_OFS && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("error on mapped address");
    a_write_zero: assert property (psel && penable && pwrite |-> prdata == 32'h00000000)
        else $error("read data during write");
    a_prdata_hold: assert property (psel && penable ##1 !psel |-> $stable(prdata)) else $error("read data moved");
    a_release_zero: assert property ($rose(reset_n) |-> (count_value == CNT_ZERO && !switch_out) [*2])
        else $error("outputs not clear after reset");
    a_reset_clears: assert property (count_reset [*8] |-> !switch_out)
        else $error("switch high while reset held");
    a_reset_freezes: assert property (count_reset [*8] |-> $stable(count_value))
        else $error("count moved while reset held");
    a_count_step: assert property (quiet_reg == 4'hF && $changed(count_value) |->
        count_value == $past(count_value) + 24'h000001 || count_value == $past(count_value) - 24'h000001)
        else $error("count moved by more than one");
endmodule
bind up_down_threshold_counter up_down_threshold_counter_monitor i_mon (.clk(clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .count_reset(count_reset), .count_value(count_value), .switch_out(switch_out));

// ### verification/up_down_threshold_counter_tb.sv
`timescale 1ns/10ps
module up_down_threshold_counter_tb import udc_pkg::*;;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [23:0] on_live_value = 24'h000000;
    logic [23:0] off_live_value = 24'h000000;
    logic [23:0] backup_count_in = 24'h000000;
    logic backup_valid = 1'b0;
    logic backup_switch_in = 1'b0;
    logic [31:0] prdata, rd_data;
    logic [23:0] backup_count_out, count_value;
    logic pready, pslverr, count_pulse, count_dir, count_reset, backup_keep, backup_switch_out, switch_out, rd_err;
    logic m_q, m_rel;
    int m_cnt, m_on, m_off, r;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [7:0] reg_ofs [8] = '{CTRL_OFS, INIT_OFS, ON_OFS, OFF_OFS, SCAN_OFS, COUNT_OFS, STATUS_OFS, 8'h1C};
    logic [31:0] reg_rst [8] = '{{25'h0, CTRL_RST}, '0, '0, '0, {16'h0, SCAN_RST}, '0, '0, '0};

    always #25 clk = ~clk;
    pulse_source i_pulse_source (.clk(clk), .pulse(count_pulse), .dir(count_dir), .rst(count_reset));
    up_down_threshold_counter i_up_down_threshold_counter (.clk(clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .count_pulse(count_pulse), .count_dir(count_dir), .count_reset(count_reset),
        .on_live_value(on_live_value), .off_live_value(off_live_value), .backup_valid(backup_valid),
        .backup_count_in(backup_count_in), .backup_switch_in(backup_switch_in), .backup_keep(backup_keep),
        .backup_count_out(backup_count_out), .backup_switch_out(backup_switch_out),
        .count_value(count_value), .switch_out(switch_out));

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic err);
        apb(1'b0, a, 32'h00000000);
        cmp("prdata", exp, rd_data);
        cmp("pslverr", {31'h0, err}, {31'h0, rd_err});
    endtask
    function automatic void eval();
        if (!m_rel) m_q = (m_cnt >= m_on);
        else if (m_on < m_off) m_q = (m_cnt >= m_on) && (m_cnt < m_off);
        else if (m_cnt >= m_on) m_q = 1'b1;
        else if (m_cnt < m_off) m_q = 1'b0;
    endfunction
    task automatic check_out();
        repeat (8) @(posedge clk);
        cmp("count_value", m_cnt, count_value);
        cmp("switch_out", m_q, switch_out);
        rd_chk(COUNT_OFS, m_cnt, 1'b0);
    endtask
    task automatic count(input int n, input logic d);
        i_pulse_source.burst(n, d, 3 + $urandom_range(2));
        for (int k = 0; k < n; k++) begin
            m_cnt = d ? ((m_cnt > 0) ? m_cnt - 1 : 0) : ((m_cnt < 9999999) ? m_cnt + 1 : m_cnt);
            eval();
        end
        check_out();
    endtask
    task automatic ctrl(input logic [31:0] v);
        apb(1'b1, CTRL_OFS, v);
        m_rel = v[CTRL_HAS_REL_BIT];
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    initial begin
        void'($urandom(78));
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        foreach (reg_ofs[i]) rd_chk(reg_ofs[i], reg_rst[i], reg_ofs[i] == 8'h1C);
        apb(1'b1, ON_OFS, 32'hFFFFFFFF);
        rd_chk(ON_OFS, {8'h00, CNT_MAX}, 1'b0);
        apb(1'b1, OFF_OFS, {8'h00, CNT_MAX});
        rd_chk(OFF_OFS, {8'h00, CNT_MAX}, 1'b0);
        $display("test registers done");
        apb(1'b1, INIT_OFS, 32'h00000005);
        apb(1'b1, ON_OFS, 32'h00000008);
        apb(1'b1, OFF_OFS, 32'h00000003);
        m_on = 8;
        m_off = 3;
        m_cnt = 5;
        m_q = 1'b0;
        ctrl(32'h00000031);
        eval();
        count(4, 1'b0);
        count(5, 1'b1);
        count(2, 1'b1);
        $display("test hysteresis done");
        fork
            i_pulse_source.hold_reset(40);
            begin
                repeat (10) @(posedge clk);
                i_pulse_source.burst(2, 1'b0, 3);
                cmp("switch_out", 0, switch_out);
                cmp("count_value", 5, count_value);
            end
        join
        m_cnt = 5;
        m_q = 1'b0;
        eval();
        check_out();
        $display("test reset done");
        apb(1'b1, ON_OFS, 32'h0000000A);
        apb(1'b1, OFF_OFS, 32'h0000000C);
        m_on = 10;
        m_off = 12;
        eval();
        apb(1'b1, SCAN_OFS, 32'h00000004);
        rd_chk(SCAN_OFS, 32'h00000004, 1'b0);
        for (int i = 0; i < 8; i++) count(1, 1'b0);
        $display("test window done");
        apb(1'b1, OFF_OFS, 32'h00000003);
        m_off = 3;
        ctrl(32'h00000001);
        i_pulse_source.hold_reset(10);
        m_cnt = 0;
        m_q = 1'b0;
        eval();
        check_out();
        count(2, 1'b1);
        count(10, 1'b0);
        ctrl(32'h00000003);
        m_cnt = 0;
        m_q = 1'b0;
        check_out();
        rd_chk(STATUS_OFS, 32'h0000000A, 1'b0);
        ctrl(32'h00000001);
        count(10, 1'b0);
        count(1, 1'b1);
        $display("test single threshold done");
        ctrl(32'h0000002D);
        for (int i = 0; i < 2; i++) begin
            m_on = i ? 20 : $urandom_range(8);
            m_off = 30;
            @(posedge clk);
            on_live_value <= 24'(m_on);
            off_live_value <= 24'(m_off);
            eval();
            check_out();
        end
        $display("test live thresholds done");
        apb(1'b1, ON_OFS, 32'h000007D0);
        apb(1'b1, OFF_OFS, 32'h00000032);
        m_on = 2000;
        m_off = 50;
        ctrl(32'h00000071);
        eval();
        repeat (4) @(posedge clk);
        cmp("backup_keep", 1, backup_keep);
        cmp("backup_count_out", m_cnt, backup_count_out);
        r = 100 + $urandom_range(999);
        @(posedge clk);
        backup_valid <= 1'b1;
        backup_count_in <= 24'(r);
        backup_switch_in <= 1'b1;
        ctrl(32'h00000070);
        ctrl(32'h00000071);
        m_cnt = r;
        m_q = 1'b1;
        eval();
        check_out();
        cmp("backup_switch_out", m_q, backup_switch_out);
        rd_chk(STATUS_OFS, 32'h0000000D, 1'b0);
        ctrl(32'h00000030);
        ctrl(32'h00000031);
        m_cnt = 5;
        m_q = 1'b0;
        eval();
        check_out();
        cmp("backup_keep", 0, backup_keep);
        $display("test retention done");
        tally_and_finish();
    end
endmodule
